// ===== verilog/mbc_misc_config.sv
// Purpose: Miscellaneous bus configuration register and the controls it steers
// Assumes: REF_CLK 25 MHz, RESET synchronous active high (power-on reset)
// Notes:   Bus reset and global reset pins are synchronised before use
//
// Notes on behaviour
// - Upper sixteen bits read zero, ignore writes
// - Bit 15 reads constant zero
// - Bits 14 to 12 read zero
// - Bit 11 reads constant one
// - Bit 10 mirrored to vendor bit 26
// - Bit 10 set lets wake bypass global enable
// - Bits 9-8 pick long read command
// - Short reads always use plain memory read
// - Bit 7 zero reports revision 010b
// - Bit 7 one reports revision 011b
// - Bits 9-7 return to 101b only on fundamental reset
// - Fundamental reset follows bus or global reset
// - Register reads 0000 0A90h after reset
`timescale 1ns/1ps
module mbc_misc_config (
	input  wire logic        REF_CLK,          // 25 MHz clock
	input  wire logic        RESET,            // Power-on reset, active high
	input  wire logic        SOFT_RESET,       // Function reset, not fundamental
	input  wire logic        PERST_N,          // Bus reset pin, active low
	input  wire logic        GLOBAL_RESET_INPUT_N,           // Global reset pin, active low
	input  wire logic        CFG_WR,           // Config write strobe
	input  wire logic        CFG_RD,           // Config read strobe
	input  wire logic [7:0]  CFG_ADDR,         // Config byte offset
	input  wire logic [3:0]  CFG_BE,           // Byte enables
	input  wire logic [31:0] CFG_WDATA,        // Write data
	output logic      [31:0] CFG_RDATA,        // Read data
	output logic             CFG_RVALID,       // Read data valid pulse
	output logic             CFG_HIT,          // Read hit this register
	input  wire logic        IRQ_PENDING,      // Any unmasked interrupt pending
	input  wire logic        GLOBAL_IRQ_ENABLE, // Global interrupt enable
	output logic             WAKE_REQ,         // Wake event request
	output logic             VENDOR_BIT26,     // Mirror for vendor id bit 26
	input  wire logic        MST_RD_REQ,       // Master read request pulse
	input  wire logic [7:0]  MST_RD_PHASES,    // Data phases of the read
	output logic      [3:0]  MST_RD_CMD,       // Command for the read
	output logic             MST_CMD_VALID,    // Command valid pulse
	output logic      [2:0]  PM_VERSION,       // Reported pm revision
	output logic             FUND_RESET_N      // Fundamental reset, active low
);
	// ==========================================================
	// Reset pin synchronisers
	logic perst_m_q;
	logic perst_s_q;
	logic global_reset_input_m_q;
	logic global_reset_input_s_q;
	logic fund_q;

	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			perst_m_q <= 1'b1;
			perst_s_q <= 1'b1;
			global_reset_input_m_q  <= 1'b1;
			global_reset_input_s_q  <= 1'b1;
		end else begin
			perst_m_q <= PERST_N;
			perst_s_q <= perst_m_q;
			global_reset_input_m_q  <= GLOBAL_RESET_INPUT_N;
			global_reset_input_s_q  <= global_reset_input_m_q;
		end
	end

	wire fund_now = RESET | ~perst_s_q | ~global_reset_input_s_q;

	always_ff @(posedge REF_CLK) begin
		fund_q <= fund_now;
	end

	// ==========================================================
	// Write decode
	wire hit    = CFG_ADDR == mbc_pkg::MISC_CFG_OFFSET;
	wire rd_hit = CFG_RD & hit;
	wire wr_b1  = CFG_WR & hit & CFG_BE[1];
	wire wr_b0  = CFG_WR & hit & CFG_BE[0];

	// ==========================================================
	// Register storage
	logic       wake_ignore_q;
	logic       wake_ignore_d;
	logic [1:0] rd_sel_q;
	logic [1:0] rd_sel_d;
	logic       pm_rev_q;
	logic       pm_rev_d;
	logic [4:0] low_ctrl_q;
	logic [4:0] low_ctrl_d;

	// Soft reset wins over a write to bit 10 in the same cycle
	assign wake_ignore_d = SOFT_RESET ? mbc_pkg::WAKE_IGNORE_RST :
		(wr_b1 ? CFG_WDATA[mbc_pkg::WAKE_IGNORE_BIT] : wake_ignore_q);
	assign rd_sel_d      = wr_b1 ?
		CFG_WDATA[mbc_pkg::RD_SEL_HI:mbc_pkg::RD_SEL_LO] : rd_sel_q;
	assign pm_rev_d      = wr_b0 ? CFG_WDATA[mbc_pkg::PM_REV_BIT] : pm_rev_q;
	assign low_ctrl_d    = wr_b0 ? CFG_WDATA[mbc_pkg::LOW_CTRL_HI:0] : low_ctrl_q;

	always_ff @(posedge REF_CLK) begin
		if (fund_now) begin
			wake_ignore_q <= mbc_pkg::WAKE_IGNORE_RST;
		end else begin
			wake_ignore_q <= wake_ignore_d;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (fund_now) begin
			rd_sel_q <= mbc_pkg::RD_SEL_RST;
		end else begin
			rd_sel_q <= rd_sel_d;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (fund_now) begin
			pm_rev_q <= mbc_pkg::PM_REV_RST;
		end else begin
			pm_rev_q <= pm_rev_d;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (fund_now) begin
			low_ctrl_q <= mbc_pkg::LOW_CTRL_RST;
		end else begin
			low_ctrl_q <= low_ctrl_d;
		end
	end

	// ==========================================================
	// Read image
	wire [31:0] image = {16'h0000,
		mbc_pkg::WAKE_UNPOWERED_VAL,
		3'h0,
		mbc_pkg::BUS_REV23_VAL,
		wake_ignore_q, rd_sel_q, pm_rev_q,
		2'h0, low_ctrl_q};

	logic [31:0] rdata_q;
	logic        rvalid_q;
	logic        hit_q;
	wire  [31:0] rdata_d = rd_hit ? image : 32'h0000_0000;

	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			rdata_q <= 32'h0000_0000;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			rvalid_q <= 1'b0;
			hit_q    <= 1'b0;
		end else begin
			rvalid_q <= CFG_RD;
			hit_q    <= rd_hit;
		end
	end

	assign CFG_RDATA  = rdata_q;
	assign CFG_RVALID = rvalid_q;
	assign CFG_HIT    = hit_q;

	// ==========================================================
	// Consumers of the controls
	logic       wake_q;
	logic       vendor_q;
	logic [3:0] cmd_q;
	logic       cmd_valid_q;
	logic [2:0] pm_ver_q;
	logic       fund_n_q;

	wire       wake_d    = IRQ_PENDING & (GLOBAL_IRQ_ENABLE | wake_ignore_q);
	wire       vendor_d  = wake_ignore_q;
	wire       short_rd  = MST_RD_PHASES <= mbc_pkg::SHORT_READ_PHASES;
	wire       sel_line  = rd_sel_q == mbc_pkg::RD_SEL_LINE;
	wire       sel_plain = rd_sel_q == mbc_pkg::RD_SEL_PLAIN;
	// Code 11 falls through to the multiple-line default
	wire [3:0] long_cmd  = sel_line ? mbc_pkg::CMD_MEM_READ_LINE :
		(sel_plain ? mbc_pkg::CMD_MEM_READ : mbc_pkg::CMD_MEM_READ_MULT);
	wire [3:0] sel_cmd   = short_rd ? mbc_pkg::CMD_MEM_READ : long_cmd;
	wire [3:0] cmd_d     = MST_RD_REQ ? sel_cmd : cmd_q;
	wire [2:0] pm_ver_d  = pm_rev_q ? mbc_pkg::PM_REV_12 :
		mbc_pkg::PM_REV_11;

	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			wake_q   <= 1'b0;
			vendor_q <= mbc_pkg::WAKE_IGNORE_RST;
		end else begin
			wake_q   <= wake_d;
			vendor_q <= vendor_d;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			cmd_q <= mbc_pkg::CMD_MEM_READ;
		end else begin
			cmd_q <= cmd_d;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			cmd_valid_q <= 1'b0;
		end else begin
			cmd_valid_q <= MST_RD_REQ;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			pm_ver_q <= mbc_pkg::PM_REV_12;
		end else begin
			pm_ver_q <= pm_ver_d;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			fund_n_q <= 1'b0;
		end else begin
			fund_n_q <= ~fund_q;
		end
	end

	assign WAKE_REQ      = wake_q;
	assign VENDOR_BIT26  = vendor_q;
	assign MST_RD_CMD    = cmd_q;
	assign MST_CMD_VALID = cmd_valid_q;
	assign PM_VERSION    = pm_ver_q;
	assign FUND_RESET_N  = fund_n_q;
endmodule

// ===== verilog/mbc_pkg.sv
// Purpose: Constants for the miscellaneous bus configuration register
// Assumes: Configuration space addressed by byte offset, dword aligned
// Notes:   Command codes follow conventional bus command encoding
package mbc_pkg;
	// ==========================================================
	// Register map
	localparam logic [7:0]  MISC_CFG_OFFSET = 8'hf0;
	localparam logic [31:0] MISC_CFG_RESET  = 32'h0000_0a90;

	// ==========================================================
	// Field positions
	localparam int WAKE_UNPOWERED_BIT = 15;
	localparam int BUS_REV23_BIT      = 11;
	localparam int WAKE_IGNORE_BIT    = 10;
	localparam int RD_SEL_HI          = 9;
	localparam int RD_SEL_LO          = 8;
	localparam int PM_REV_BIT         = 7;
	localparam int LOW_CTRL_HI        = 4;

	// ==========================================================
	// Field defaults
	localparam logic       WAKE_UNPOWERED_VAL = 1'b0;
	localparam logic       BUS_REV23_VAL      = 1'b1;
	localparam logic       WAKE_IGNORE_RST    = 1'b0;
	localparam logic [1:0] RD_SEL_RST         = 2'h2;
	localparam logic       PM_REV_RST         = 1'b1;
	localparam logic [4:0] LOW_CTRL_RST       = 5'h10;

	// ==========================================================
	// Read command selection codes
	localparam logic [1:0] RD_SEL_LINE     = 2'h0;
	localparam logic [1:0] RD_SEL_PLAIN    = 2'h1;
	localparam logic [1:0] RD_SEL_MULTIPLE = 2'h2;

	// Bus command encodings issued by the master
	localparam logic [3:0] CMD_MEM_READ      = 4'h6;
	localparam logic [3:0] CMD_MEM_READ_LINE = 4'he;
	localparam logic [3:0] CMD_MEM_READ_MULT = 4'hc;

	// Longest read that always uses a plain memory read
	localparam logic [7:0] SHORT_READ_PHASES = 8'h02;

	// Power-management revision codes
	localparam logic [2:0] PM_REV_11 = 3'h2;
	localparam logic [2:0] PM_REV_12 = 3'h3;
endpackage

// ===== dv/mbc_chk.sv
// Purpose: Assertions on the misc config register ports
// Assumes: Bound to mbc_misc_config
// Notes:   One cycle output latency, four cycles from reset pins to FUND_RESET_N
`timescale 1ns/1ps
module mbc_chk (
	input wire logic        REF_CLK,           // Clock
	input wire logic        RESET,             // Reset
	input wire logic        PERST_N,           // Bus reset pin
	input wire logic        GLOBAL_RESET_INPUT_N,            // Global reset pin
	input wire logic [31:0] CFG_RDATA,         // Read data
	input wire logic        CFG_HIT,           // Hit
	input wire logic        IRQ_PENDING,       // Irq
	input wire logic        GLOBAL_IRQ_ENABLE, // Gate
	input wire logic        WAKE_REQ,          // Wake
	input wire logic        VENDOR_BIT26,      // Mirror
	input wire logic        MST_RD_REQ,        // Request
	input wire logic [7:0]  MST_RD_PHASES,     // Phases
	input wire logic [3:0]  MST_RD_CMD,        // Command
	input wire logic        MST_CMD_VALID,     // Cmd valid
	input wire logic [2:0]  PM_VERSION,        // Version
	input wire logic        FUND_RESET_N       // Fundamental reset
);
	// ==========================================================
	// Checks
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (RESET);
	chk_upper_zero: assert property (CFG_HIT |-> CFG_RDATA[31:16] == 16'h0)
		else $error("upper bits set");
	chk_bit15_zero: assert property (CFG_HIT |-> !CFG_RDATA[15])
		else $error("bit 15 set");
	chk_rsvd_zero: assert property (CFG_HIT |-> CFG_RDATA[14:12] == 3'h0)
		else $error("reserved bits set");
	chk_bit11_one: assert property (CFG_HIT |-> CFG_RDATA[11])
		else $error("bit 11 clear");
	chk_mirror_bit: assert property (CFG_HIT |-> VENDOR_BIT26 == CFG_RDATA[10])
		else $error("mirror differs");
	chk_wake_gate: assert property (!$past(RESET) |-> WAKE_REQ ==
		($past(IRQ_PENDING) && ($past(GLOBAL_IRQ_ENABLE) || VENDOR_BIT26))) else $error("bad wake");
	chk_pm_version: assert property (CFG_HIT |-> PM_VERSION == {2'h1, CFG_RDATA[7]})
		else $error("bad version");
	chk_short_read: assert property (MST_RD_REQ && MST_RD_PHASES <= 8'h02 |=>
		MST_CMD_VALID && MST_RD_CMD == 4'h6) else $error("short read command");
	chk_bus_rst_fund: assert property ((!PERST_N) [*4] |=> !FUND_RESET_N)
		else $error("bus reset not passed on");
	chk_glob_rst_fund: assert property ((!GLOBAL_RESET_INPUT_N) [*4] |=> !FUND_RESET_N)
		else $error("global reset not passed on");
	chk_cmd_hold: assert property (!MST_RD_REQ |=> !MST_CMD_VALID && $stable(MST_RD_CMD))
		else $error("command changed without request");
endmodule

bind mbc_misc_config mbc_chk u_chk (.REF_CLK(REF_CLK), .RESET(RESET), .PERST_N(PERST_N),
	.GLOBAL_RESET_INPUT_N(GLOBAL_RESET_INPUT_N), .CFG_RDATA(CFG_RDATA),
	.CFG_HIT(CFG_HIT), .IRQ_PENDING(IRQ_PENDING), .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE),
	.WAKE_REQ(WAKE_REQ), .VENDOR_BIT26(VENDOR_BIT26), .MST_RD_REQ(MST_RD_REQ),
	.MST_RD_PHASES(MST_RD_PHASES), .MST_RD_CMD(MST_RD_CMD), .MST_CMD_VALID(MST_CMD_VALID),
	.PM_VERSION(PM_VERSION), .FUND_RESET_N(FUND_RESET_N));

// ===== dv/mbc_misc_config_tb.sv
// Purpose: Directed bench for the misc config register
// Assumes: Inputs change on the falling edge
// Notes:   One task per scenario
`timescale 1ns/1ps
module mbc_misc_config_tb;
	// ==========================================================
	// Bench
	logic        clk, rst, srst, prn, grn, wr, rd, irq, gie, mreq, hit, rv, wake, v26, cv, frn;
	logic [7:0]  addr, ph;
	logic [3:0]  be, cmd;
	logic [31:0] wd, rdat;
	logic [2:0]  pmv;
	int          n_mismatch = 0, n_checks = 0;
	mbc_misc_config DUT (.REF_CLK(clk), .RESET(rst), .SOFT_RESET(srst), .PERST_N(prn),
		.GLOBAL_RESET_INPUT_N(grn), .CFG_WR(wr), .CFG_RD(rd), .CFG_ADDR(addr), .CFG_BE(be), .CFG_WDATA(wd),
		.CFG_RDATA(rdat), .CFG_RVALID(rv), .CFG_HIT(hit), .IRQ_PENDING(irq),
		.GLOBAL_IRQ_ENABLE(gie), .WAKE_REQ(wake), .VENDOR_BIT26(v26), .MST_RD_REQ(mreq),
		.MST_RD_PHASES(ph), .MST_RD_CMD(cmd), .MST_CMD_VALID(cv), .PM_VERSION(pmv),
		.FUND_RESET_N(frn));
	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: %h vs %h", $time, seen, exp);
		end
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task wr_reg(input logic [31:0] d, input logic [3:0] b);
		@(negedge clk) {wr, addr, be, wd} = {1'b1, 8'hf0, b, d};
		@(negedge clk) wr = 0;
	endtask
	task rd_reg(input logic [7:0] a, input logic [31:0] exp);
		@(negedge clk) {rd, addr} = {1'b1, a};
		@(negedge clk) rd = 0;
		check({30'h0, hit, rv}, {30'h0, a == 8'hf0, 1'b1});
		check(rdat, exp);
	endtask
	task mst(input logic [7:0] p, input logic [3:0] exp);
		@(negedge clk) {mreq, ph} = {1'b1, p};
		@(negedge clk) mreq = 0;
		check({cv, cmd}, {1'b1, exp});
	endtask
	task t_fields;
		rd_reg(8'hf0, 32'h0000_0a90);
		rd_reg(8'hf4, 0);
		wr_reg(32'hffff_ffff, 4'hf);
		rd_reg(8'hf0, 32'h0000_0f9f);
		check({v26, pmv}, 4'hb);
		wr_reg(0, 4'hf);
		rd_reg(8'hf0, 32'h0000_0800);
		check({v26, pmv}, 4'h2);
		wr_reg(32'hffff_ffff, 4'hc);
		rd_reg(8'hf0, 32'h0000_0800);
		$display("t_fields done");
	endtask
	task t_cmd;
		logic [3:0] tbl [4] = '{4'he, 4'h6, 4'hc, 4'hc};
		for (int s = 0; s < 4; s++) begin
			wr_reg({22'h0, s[1:0], 8'h0}, 4'h2);
			mst(8'h03, tbl[s]);
			mst(8'h02, 4'h6);
		end
		$display("t_cmd done");
	endtask
	task t_wake;
		{irq, gie} = 2'b10;
		repeat (2) @(negedge clk);
		check(wake, 0);
		wr_reg(32'h400, 4'h2);
		repeat (2) @(negedge clk);
		check(wake, 1);
		$display("t_wake done");
	endtask
	task t_resets;
		wr_reg(32'h580, 4'h3);
		@(negedge clk) srst = 1;
		@(negedge clk) srst = 0;
		rd_reg(8'hf0, 32'h0000_0980);
		for (int i = 0; i < 2; i++) begin
			wr_reg(0, 4'h3);
			{prn, grn} = i ? 2'b10 : 2'b01;
			repeat (4) @(negedge clk);
			check(frn, 0);
			{prn, grn} = 2'b11;
			repeat (4) @(negedge clk);
			check(frn, 1);
			rd_reg(8'hf0, 32'h0000_0a90);
		end
		wr_reg(0, 4'h3);
		@(negedge clk) rst = 1;
		@(negedge clk) rst = 0;
		check(frn, 0);
		rd_reg(8'hf0, 32'h0000_0a90);
		check({v26, pmv}, 4'h3);
		check(frn, 1);
		$display("t_resets done");
	endtask
	initial begin
		clk = 0;
		forever #20 clk = ~clk;
	end
	initial begin
		{rst, srst, prn, grn, wr, rd, irq, gie, mreq} = 9'h160;
		{addr, be, wd, ph} = '0;
		repeat (4) @(negedge clk);
		rst = 0;
		t_fields;
		t_cmd;
		t_wake;
		t_resets;
		finish_test;
	end
endmodule
